// ### common/tcc_pkg.sv
// constants for the timer capture/compare configuration block
package tcc_pkg;
	// byte offsets on the register bus
	localparam logic [11:0] OFF_OUTPUT_CONTROL_TWO = 12'h130;
	localparam logic [11:0] OFF_CAPTURE_IO_CD = 12'h134;
	localparam logic [11:0] OFF_CAPTURE_IO_AB = 12'h138;
	localparam logic [11:0] OFF_MODE = 12'h13c;
	localparam logic [11:0] OFF_GENERAL_A = 12'h140;
	localparam logic [11:0] OFF_GENERAL_B = 12'h144;
	localparam logic [11:0] OFF_GENERAL_C = 12'h148;
	localparam logic [11:0] OFF_GENERAL_D = 12'h14c;
	localparam logic [11:0] OFF_COUNTER = 12'h150;
	// reset values
	localparam logic [7:0] RST_OUTPUT_CONTROL_TWO = 8'h18;
	localparam logic [7:0] RST_CAPTURE_IO_CD = 8'h88;
	localparam logic [7:0] RST_CAPTURE_IO_AB = 8'h88;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [15:0] RST_GENERAL = 16'hffff;
	localparam logic [15:0] RST_COUNTER = 16'h0000;
	// unassigned bits of output_control_two that read as one
	localparam logic [7:0] OCT2_ONES_MASK = 8'h18;
	// output_control_two field positions
	localparam int POS_POL_B = 0;
	localparam int POS_POL_C = 1;
	localparam int POS_POL_D = 2;
	localparam int POS_STOP_ON_MATCH = 5;
	localparam int POS_TRIG_EDGE_LO = 6;
	// capture io control field positions (low channel, high channel)
	localparam int POS_EDGE_LO_0 = 0;
	localparam int POS_MODE_SEL_0 = 2;
	localparam int POS_EDGE_LO_1 = 4;
	localparam int POS_MODE_SEL_1 = 6;
	// mode_register field positions
	localparam int POS_PWM_MODE = 0;
	localparam int POS_SINGLE_PIN_PWM = 1;
	localparam int POS_BUF_SEL_C = 4;
	localparam int POS_BUF_SEL_D = 5;
	localparam int POS_START = 7;
	// capture edge codes
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	localparam logic [1:0] EDGE_NONE = 2'h3;
	// trigger edge codes
	localparam logic [1:0] TRIG_NONE = 2'h0;
	localparam logic [1:0] TRIG_RISE = 2'h1;
	localparam logic [1:0] TRIG_FALL = 2'h2;
	localparam logic [1:0] TRIG_BOTH = 2'h3;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### common/edge_if.sv
// carrier between the top and one edge detector
`timescale 1ns/1ps
interface edge_if;
	logic pin; // raw pin level
	logic [1:0] sel; // edge code
	logic hit; // one-cycle edge pulse
	modport det (input pin, input sel, output hit);
	modport user (output pin, output sel, input hit);
endinterface

// ### rtl/edge_capture.sv
// synchroniser and qualified edge detector for one pin
`timescale 1ns/1ps
module edge_capture (
	input wire logic aclk,
	input wire logic aresetn,
	edge_if.det port
);
	logic sync1_reg; // first stage, read only by sync2
	logic sync2_reg; // stable level
	logic prev_reg; // level one cycle earlier
	logic rise;
	logic fall;

	// two-flop synchroniser plus history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			sync1_reg <= port.pin;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	assign rise = sync2_reg & ~prev_reg;
	assign fall = ~sync2_reg & prev_reg;

	// edge qualification by code
	always_comb begin
		unique case (port.sel)
			tcc_pkg::EDGE_RISE: port.hit = rise;
			tcc_pkg::EDGE_FALL: port.hit = fall;
			tcc_pkg::EDGE_BOTH: port.hit = rise | fall;
			tcc_pkg::EDGE_NONE: port.hit = 1'b0;
		endcase
	end
endmodule

// ### rtl/timer_capture_compare_config.sv
// 16-bit capture/compare timer with its configuration registers on AXI4-Lite
`timescale 1ns/1ps
module timer_capture_compare_config (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic channel_pin_a_in,
	input wire logic channel_pin_b_in,
	output logic channel_pin_b_out,
	output logic channel_pin_b_oe,
	input wire logic channel_pin_c_in,
	output logic channel_pin_c_out,
	output logic channel_pin_c_oe,
	input wire logic channel_pin_d_in,
	output logic channel_pin_d_out,
	output logic channel_pin_d_oe,
	input wire logic trigger_input
);
	// configuration state
	logic [7:0] output_control_two_reg; // polarity, stop, trigger
	logic [7:0] capture_io_control_cd_reg; // edge and mode for C, D
	logic [7:0] capture_io_control_ab_reg; // edge and mode for A, B
	logic [7:0] mode_register_reg; // pwm modes, buffers, start
	logic [15:0] main_counter_reg; // the count
	logic [15:0] general_reg_a_reg;
	logic [15:0] general_reg_b_reg;
	logic [15:0] general_reg_c_reg;
	logic [15:0] general_reg_d_reg;
	// bus write holding
	logic aw_full_reg;
	logic w_full_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	// decoded fields
	logic pwm_mode;
	logic single_pin_pwm_mode;
	logic buffer_select_c;
	logic buffer_select_d;
	logic mode_select_a;
	logic mode_select_b;
	logic mode_select_c;
	logic mode_select_d;
	logic stop_on_match;
	logic [1:0] trigger_edge;
	logic running;
	logic match_a;
	logic compare_active;
	// edge detector wiring: 0..3 channels A..D, 4 trigger
	logic [4:0] pin_v;
	logic [1:0] sel_v [5];
	logic [4:0] hit_v;
	logic [1:0] trig_code;
	// write strobes
	logic wr_fire;
	logic wr_mapped;
	logic [7:0] wr_byte;

	assign pwm_mode = mode_register_reg[tcc_pkg::POS_PWM_MODE];
	assign single_pin_pwm_mode = mode_register_reg[tcc_pkg::POS_SINGLE_PIN_PWM];
	assign buffer_select_c = mode_register_reg[tcc_pkg::POS_BUF_SEL_C];
	assign buffer_select_d = mode_register_reg[tcc_pkg::POS_BUF_SEL_D];
	assign running = mode_register_reg[tcc_pkg::POS_START];
	assign mode_select_a = capture_io_control_ab_reg[tcc_pkg::POS_MODE_SEL_0];
	assign mode_select_b = capture_io_control_ab_reg[tcc_pkg::POS_MODE_SEL_1];
	assign mode_select_c = capture_io_control_cd_reg[tcc_pkg::POS_MODE_SEL_0];
	assign mode_select_d = capture_io_control_cd_reg[tcc_pkg::POS_MODE_SEL_1];
	assign stop_on_match = output_control_two_reg[tcc_pkg::POS_STOP_ON_MATCH];
	assign trigger_edge = output_control_two_reg[tcc_pkg::POS_TRIG_EDGE_LO +: 2];
	assign match_a = main_counter_reg == general_reg_a_reg;
	// compare engine is live outside capture on A, or in either pwm mode
	assign compare_active = pwm_mode | single_pin_pwm_mode | ~mode_select_a;

	// trigger codes mapped onto detector codes
	always_comb begin
		unique case (trigger_edge)
			tcc_pkg::TRIG_RISE: trig_code = tcc_pkg::EDGE_RISE;
			tcc_pkg::TRIG_FALL: trig_code = tcc_pkg::EDGE_FALL;
			tcc_pkg::TRIG_BOTH: trig_code = tcc_pkg::EDGE_BOTH;
			tcc_pkg::TRIG_NONE: trig_code = tcc_pkg::EDGE_NONE;
		endcase
	end

	assign pin_v = {trigger_input, channel_pin_d_in, channel_pin_c_in,
		channel_pin_b_in, channel_pin_a_in};
	assign sel_v[0] = capture_io_control_ab_reg[tcc_pkg::POS_EDGE_LO_0 +: 2];
	assign sel_v[1] = capture_io_control_ab_reg[tcc_pkg::POS_EDGE_LO_1 +: 2];
	assign sel_v[2] = capture_io_control_cd_reg[tcc_pkg::POS_EDGE_LO_0 +: 2];
	assign sel_v[3] = capture_io_control_cd_reg[tcc_pkg::POS_EDGE_LO_1 +: 2];
	assign sel_v[4] = single_pin_pwm_mode ? trig_code : tcc_pkg::EDGE_NONE;

	// one synchronised edge detector per pin
	edge_if eif [5] ();
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_edge
			assign eif[gi].pin = pin_v[gi];
			assign eif[gi].sel = sel_v[gi];
			assign hit_v[gi] = eif[gi].hit;
			edge_capture u_edge (
				.aclk(aclk),
				.aresetn(aresetn),
				.port(eif[gi])
			);
		end
	endgenerate

	// bus handshake: address and data taken in any order
	assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
	assign wr_byte = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;
	always_comb begin
		unique case (awaddr_reg)
			tcc_pkg::OFF_OUTPUT_CONTROL_TWO, tcc_pkg::OFF_CAPTURE_IO_CD,
			tcc_pkg::OFF_CAPTURE_IO_AB, tcc_pkg::OFF_MODE,
			tcc_pkg::OFF_GENERAL_A, tcc_pkg::OFF_GENERAL_B,
			tcc_pkg::OFF_GENERAL_C, tcc_pkg::OFF_GENERAL_D,
			tcc_pkg::OFF_COUNTER: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	// write channel holding and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tcc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel: one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= tcc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= tcc_pkg::RESP_OKAY;
			unique case ({s_axi_araddr[11:2], 2'b00})
				tcc_pkg::OFF_OUTPUT_CONTROL_TWO:
					s_axi_rdata <= {24'h0, output_control_two_reg | tcc_pkg::OCT2_ONES_MASK};
				tcc_pkg::OFF_CAPTURE_IO_CD: s_axi_rdata <= {24'h0, capture_io_control_cd_reg};
				tcc_pkg::OFF_CAPTURE_IO_AB: s_axi_rdata <= {24'h0, capture_io_control_ab_reg};
				tcc_pkg::OFF_MODE: s_axi_rdata <= {24'h0, mode_register_reg};
				tcc_pkg::OFF_GENERAL_A: s_axi_rdata <= {16'h0, general_reg_a_reg};
				tcc_pkg::OFF_GENERAL_B: s_axi_rdata <= {16'h0, general_reg_b_reg};
				tcc_pkg::OFF_GENERAL_C: s_axi_rdata <= {16'h0, general_reg_c_reg};
				tcc_pkg::OFF_GENERAL_D: s_axi_rdata <= {16'h0, general_reg_d_reg};
				tcc_pkg::OFF_COUNTER: s_axi_rdata <= {16'h0, main_counter_reg};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= tcc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// byte-wide configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			output_control_two_reg <= tcc_pkg::RST_OUTPUT_CONTROL_TWO;
			capture_io_control_cd_reg <= tcc_pkg::RST_CAPTURE_IO_CD;
			capture_io_control_ab_reg <= tcc_pkg::RST_CAPTURE_IO_AB;
		end else if (wr_fire && wstrb_reg[0]) begin
			if (awaddr_reg == tcc_pkg::OFF_OUTPUT_CONTROL_TWO) begin
				output_control_two_reg <= wr_byte | tcc_pkg::OCT2_ONES_MASK;
			end
			if (awaddr_reg == tcc_pkg::OFF_CAPTURE_IO_CD) begin
				capture_io_control_cd_reg <= wr_byte;
			end
			if (awaddr_reg == tcc_pkg::OFF_CAPTURE_IO_AB) begin
				capture_io_control_ab_reg <= wr_byte;
			end
		end
	end

	// mode register; start cleared on stop match, set by trigger in single-pin pwm mode (set wins)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_register_reg <= tcc_pkg::RST_MODE;
		end else begin
			if (wr_fire && wstrb_reg[0] && awaddr_reg == tcc_pkg::OFF_MODE) begin
				mode_register_reg <= wr_byte;
			end else if (running && match_a && stop_on_match && compare_active) begin
				mode_register_reg[tcc_pkg::POS_START] <= 1'b0;
			end
			if (hit_v[4]) begin
				mode_register_reg[tcc_pkg::POS_START] <= 1'b1;
			end
		end
	end

	// counter: wraps on A match in pwm modes, halts on A match when stop is chosen and the compare engine is live
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_counter_reg <= tcc_pkg::RST_COUNTER;
		end else if (wr_fire && awaddr_reg == tcc_pkg::OFF_COUNTER) begin
			if (wstrb_reg[0]) main_counter_reg[7:0] <= wdata_reg[7:0];
			if (wstrb_reg[1]) main_counter_reg[15:8] <= wdata_reg[15:8];
		end else if (running) begin
			if (match_a && stop_on_match && compare_active) begin
				main_counter_reg <= main_counter_reg;
			end else if (match_a && (pwm_mode || single_pin_pwm_mode)) begin
				main_counter_reg <= tcc_pkg::RST_COUNTER;
			end else begin
				main_counter_reg <= main_counter_reg + 16'h0001;
			end
		end
	end

	// general registers; a capture beats a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			general_reg_a_reg <= tcc_pkg::RST_GENERAL;
			general_reg_b_reg <= tcc_pkg::RST_GENERAL;
			general_reg_c_reg <= tcc_pkg::RST_GENERAL;
			general_reg_d_reg <= tcc_pkg::RST_GENERAL;
		end else begin
			if (wr_fire && awaddr_reg == tcc_pkg::OFF_GENERAL_A) begin
				if (wstrb_reg[0]) general_reg_a_reg[7:0] <= wdata_reg[7:0];
				if (wstrb_reg[1]) general_reg_a_reg[15:8] <= wdata_reg[15:8];
			end
			if (wr_fire && awaddr_reg == tcc_pkg::OFF_GENERAL_B) begin
				if (wstrb_reg[0]) general_reg_b_reg[7:0] <= wdata_reg[7:0];
				if (wstrb_reg[1]) general_reg_b_reg[15:8] <= wdata_reg[15:8];
			end
			if (wr_fire && awaddr_reg == tcc_pkg::OFF_GENERAL_C) begin
				if (wstrb_reg[0]) general_reg_c_reg[7:0] <= wdata_reg[7:0];
				if (wstrb_reg[1]) general_reg_c_reg[15:8] <= wdata_reg[15:8];
			end
			if (wr_fire && awaddr_reg == tcc_pkg::OFF_GENERAL_D) begin
				if (wstrb_reg[0]) general_reg_d_reg[7:0] <= wdata_reg[7:0];
				if (wstrb_reg[1]) general_reg_d_reg[15:8] <= wdata_reg[15:8];
			end
			// channel A capture, with transfer into C when C buffers A
			if (hit_v[0] && mode_select_a) begin
				general_reg_a_reg <= main_counter_reg;
				if (buffer_select_c) general_reg_c_reg <= general_reg_a_reg;
			end
			if (hit_v[1] && mode_select_b) begin
				general_reg_b_reg <= main_counter_reg;
				if (buffer_select_d) general_reg_d_reg <= general_reg_b_reg;
			end
			// own-pin capture for C and D only when not buffering
			if (hit_v[2] && mode_select_c && !buffer_select_c) begin
				general_reg_c_reg <= main_counter_reg;
			end
			if (hit_v[3] && mode_select_d && !buffer_select_d) begin
				general_reg_d_reg <= main_counter_reg;
			end
		end
	end

	// pwm outputs: active while count is below the channel register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_pin_b_out <= 1'b0;
			channel_pin_c_out <= 1'b0;
			channel_pin_d_out <= 1'b0;
			channel_pin_b_oe <= 1'b0;
			channel_pin_c_oe <= 1'b0;
			channel_pin_d_oe <= 1'b0;
		end else begin
			channel_pin_b_oe <= (pwm_mode || single_pin_pwm_mode) && !mode_select_b;
			channel_pin_c_oe <= pwm_mode && !mode_select_c;
			channel_pin_d_oe <= pwm_mode && !mode_select_d;
			if (pwm_mode) begin
				channel_pin_b_out <= (main_counter_reg < general_reg_b_reg) ~^
					output_control_two_reg[tcc_pkg::POS_POL_B];
				channel_pin_c_out <= (main_counter_reg < general_reg_c_reg) ~^
					output_control_two_reg[tcc_pkg::POS_POL_C];
				channel_pin_d_out <= (main_counter_reg < general_reg_d_reg) ~^
					output_control_two_reg[tcc_pkg::POS_POL_D];
			end else begin
				// polarity has no effect outside pwm mode
				channel_pin_b_out <= single_pin_pwm_mode &&
					(main_counter_reg < general_reg_b_reg);
				channel_pin_c_out <= 1'b0;
				channel_pin_d_out <= 1'b0;
			end
		end
	end
endmodule

// ### test/pin_model.sv
// far-side model: drives the capture and trigger pins
`timescale 1ns/1ps
module pin_model (
	input wire logic aclk,
	input wire logic pin_b_out,
	input wire logic pin_b_oe,
	input wire logic pin_c_out,
	input wire logic pin_c_oe,
	input wire logic pin_d_out,
	input wire logic pin_d_oe,
	output logic pin_a,
	output logic pin_b,
	output logic pin_c,
	output logic pin_d,
	output logic trig
);
	// levels offered by the far side: a, b, c, d, trigger
	logic [4:0] lvl;
	initial lvl = 5'h00;
	// wire level: the block wins while it drives
	assign pin_a = lvl[0];
	assign pin_b = pin_b_oe ? pin_b_out : lvl[1];
	assign pin_c = pin_c_oe ? pin_c_out : lvl[2];
	assign pin_d = pin_d_oe ? pin_d_out : lvl[3];
	assign trig = lvl[4];
	// change one pin after an edge, then hold it for a while
	task automatic drive(input int idx, input logic v, input int hold);
		@(posedge aclk);
		lvl[idx] <= v;
		repeat (hold) @(posedge aclk);
	endtask
endmodule

// ### test/tcc_asserts.sv
// bus handshake and readback checks on the block's ports
`timescale 1ns/1ps
module tcc_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic channel_pin_b_oe
);
	// single domain, all checks off in reset
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic ar_go; // read address taken
	assign ar_go = s_axi_arvalid && s_axi_arready;
	wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel open while response pending");
	// both taken on one edge: the write fires the next cycle, bvalid stands one later
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	rd_answer_a: assert property (ar_go |=> s_axi_rvalid) else $error("read data late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
	rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open while data pending");
	ones_read_a: assert property (ar_go && s_axi_araddr == tcc_pkg::OFF_OUTPUT_CONTROL_TWO
		|=> s_axi_rdata[4:3] == 2'h3) else $error("unassigned bits not one");
	bad_read_a: assert property (ar_go && s_axi_araddr == 12'h1fc |=> s_axi_rdata == 32'h0
		&& s_axi_rresp == tcc_pkg::RESP_SLVERR) else $error("unmapped read answered");
	// main scenarios reached
	cover property (s_axi_bvalid && !s_axi_bready);
	cover property (s_axi_rvalid && !s_axi_rready);
	cover property ($rose(channel_pin_b_oe));
endmodule
bind timer_capture_compare_config tcc_asserts tcc_asserts_i (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_pin_b_oe);

// ### test/test_timer_capture_compare_config.sv
// bench: register traffic over the bus plus pin stimulus
`timescale 1ns/1ps
module test_timer_capture_compare_config;
	logic aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic pin_a, pin_b, pin_c, pin_d, trig; // wire levels
	logic out_b, out_c, out_d, oe_b, oe_c, oe_d; // block pin drive
	logic [31:0] rd_data, v; // last read data, saved value
	logic [1:0] last_resp; // last bus response
	logic [11:0] ga; // general register under test
	logic [2:0] pol; // polarity pattern
	logic [15:0] gv; // compare value
	int err_total, tests_run, i, ch, cd;
	// expected capture results per edge code, after rise and after fall
	logic [31:0] ex_r [4] = '{32'h0100, 32'hffff, 32'h0100, 32'hffff};
	logic [31:0] ex_f [4] = '{32'h0100, 32'h0200, 32'h0200, 32'hffff};
	logic [11:0] ra [6] = '{12'h130, 12'h134, 12'h138, 12'h13c, 12'h140, 12'h150};
	logic [31:0] rv [6] = '{32'h18, 32'h88, 32'h88, 32'h0, 32'hffff, 32'h0};
	timer_capture_compare_config timer_capture_compare_config_i (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .channel_pin_a_in(pin_a), .channel_pin_b_in(pin_b),
		.channel_pin_b_out(out_b), .channel_pin_b_oe(oe_b), .channel_pin_c_in(pin_c),
		.channel_pin_c_out(out_c), .channel_pin_c_oe(oe_c), .channel_pin_d_in(pin_d),
		.channel_pin_d_out(out_d), .channel_pin_d_oe(oe_d), .trigger_input(trig));
	pin_model pin_model_i (.aclk, .pin_b_out(out_b), .pin_b_oe(oe_b), .pin_c_out(out_c),
		.pin_c_oe(oe_c), .pin_d_out(out_d), .pin_d_oe(oe_d), .pin_a, .pin_b, .pin_c,
		.pin_d, .trig);
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one write; readiness sampled mid-cycle, changes land after the edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input int lag);
		int n;
		bit ka, kw, kb;
		n = 0;
		kb = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		while (!kb && n < 60) begin
			@(negedge aclk);
			ka = s_axi_awvalid && s_axi_awready;
			kw = s_axi_wvalid && s_axi_wready;
			kb = s_axi_bready && s_axi_bvalid;
			if (kb) last_resp = s_axi_bresp;
			@(posedge aclk);
			n++;
			if (ka) s_axi_awvalid <= 1'b0;
			if (kw) s_axi_wvalid <= 1'b0;
			if (kb) s_axi_bready <= 1'b0;
			else if (n >= lag) s_axi_bready <= 1'b1;
		end
		if (!kb) chk(32'h0, 32'h1, "write unanswered");
	endtask
	// one read, rready raised after lag cycles
	task automatic rd(input logic [11:0] a, input int lag);
		int n;
		bit ka, kr;
		n = 0;
		kr = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		while (!kr && n < 60) begin
			@(negedge aclk);
			ka = s_axi_arvalid && s_axi_arready;
			kr = s_axi_rready && s_axi_rvalid;
			if (kr) rd_data = s_axi_rdata;
			if (kr) last_resp = s_axi_rresp;
			@(posedge aclk);
			n++;
			if (ka) s_axi_arvalid <= 1'b0;
			if (kr) s_axi_rready <= 1'b0;
			else if (n >= lag) s_axi_rready <= 1'b1;
		end
		if (!kr) chk(32'h0, 32'h1, "read unanswered");
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
		rd(a, 0);
		chk(rd_data, exp, m);
	endtask
	// pin edge, held long enough for the detector
	task automatic cap(input int idx, input logic val);
		pin_model_i.drive(idx, val, 6);
	endtask
	task automatic endt(input string s);
		$display("test %s ended, %0d checks", s, tests_run);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// hang guard
	initial begin
		#300000;
		chk(32'h0, 32'h1, "watchdog");
		close_out();
	end
	// main sequence
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		err_total = 0;
		tests_run = 0;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		for (i = 0; i < 6; i++) rdc(ra[i], rv[i], "reset value");
		wr(tcc_pkg::OFF_OUTPUT_CONTROL_TWO, 32'h0, 3);
		chk({30'h0, last_resp}, {30'h0, tcc_pkg::RESP_OKAY}, "mapped write");
		rdc(tcc_pkg::OFF_OUTPUT_CONTROL_TWO, 32'h18, "ones kept");
		wr(tcc_pkg::OFF_OUTPUT_CONTROL_TWO, 32'he7, 0);
		rd(tcc_pkg::OFF_OUTPUT_CONTROL_TWO, 2);
		chk(rd_data, 32'hff, "all ones");
		wr(12'h1fc, 32'h5a, 0);
		chk({30'h0, last_resp}, {30'h0, tcc_pkg::RESP_SLVERR}, "unmapped write");
		rdc(12'h1fc, 32'h0, "unmapped read");
		chk({30'h0, last_resp}, {30'h0, tcc_pkg::RESP_SLVERR}, "unmapped read resp");
		endt("registers");
		wr(tcc_pkg::OFF_MODE, 32'h0, 0);
		for (ch = 0; ch < 2; ch++) begin
			for (cd = 0; cd < 4; cd++) begin
				ga = ch ? tcc_pkg::OFF_GENERAL_D : tcc_pkg::OFF_GENERAL_C;
				v = ch ? {24'h0, 2'h3, cd[1:0], 4'h0} : {28'h0, 2'h3, cd[1:0]};
				wr(tcc_pkg::OFF_CAPTURE_IO_CD, v, 0);
				wr(ga, 32'hffff, 0);
				wr(tcc_pkg::OFF_COUNTER, 32'h0100, 0);
				cap(ch + 2, 1'b1);
				rdc(ga, ex_r[cd], "capture at rise");
				wr(tcc_pkg::OFF_COUNTER, 32'h0200, 0);
				cap(ch + 2, 1'b0);
				rdc(ga, ex_f[cd], "capture at fall");
			end
		end
		endt("edges");
		wr(tcc_pkg::OFF_CAPTURE_IO_AB, 32'h0c, 0);
		wr(tcc_pkg::OFF_CAPTURE_IO_CD, 32'h0c, 0);
		wr(tcc_pkg::OFF_MODE, 32'h10, 0);
		wr(tcc_pkg::OFF_GENERAL_A, 32'h1111, 0);
		wr(tcc_pkg::OFF_GENERAL_C, 32'h2222, 0);
		wr(tcc_pkg::OFF_COUNTER, 32'h0300, 0);
		cap(0, 1'b1);
		rdc(tcc_pkg::OFF_GENERAL_A, 32'h0300, "A capture");
		rdc(tcc_pkg::OFF_GENERAL_C, 32'h1111, "C takes old A");
		wr(tcc_pkg::OFF_COUNTER, 32'h0400, 0);
		cap(2, 1'b1);
		rdc(tcc_pkg::OFF_GENERAL_C, 32'h1111, "C pin ignored");
		cap(2, 1'b0);
		wr(tcc_pkg::OFF_CAPTURE_IO_AB, 32'hc0, 0);
		wr(tcc_pkg::OFF_COUNTER, 32'h0500, 0);
		cap(1, 1'b1);
		rdc(tcc_pkg::OFF_GENERAL_B, 32'h0500, "B capture");
		cap(1, 1'b0);
		endt("buffer");
		wr(tcc_pkg::OFF_COUNTER, 32'hfffe, 0);
		wr(tcc_pkg::OFF_MODE, 32'h80, 0);
		rd(tcc_pkg::OFF_COUNTER, 0);
		v = rd_data;
		chk({31'h0, v < 32'h40}, 32'h1, "sixteen bit wrap");
		rd(tcc_pkg::OFF_COUNTER, 0);
		chk({31'h0, rd_data > v}, 32'h1, "counting up");
		wr(tcc_pkg::OFF_MODE, 32'h0, 0);
		wr(tcc_pkg::OFF_CAPTURE_IO_AB, 32'h88, 0);
		wr(tcc_pkg::OFF_GENERAL_A, 32'h0010, 0);
		wr(tcc_pkg::OFF_COUNTER, 32'h0, 0);
		wr(tcc_pkg::OFF_OUTPUT_CONTROL_TWO, 32'h20, 0);
		wr(tcc_pkg::OFF_MODE, 32'h80, 0);
		repeat (40) @(posedge aclk);
		rdc(tcc_pkg::OFF_COUNTER, 32'h0010, "stopped at match");
		rdc(tcc_pkg::OFF_MODE, 32'h0, "start cleared");
		wr(tcc_pkg::OFF_OUTPUT_CONTROL_TWO, 32'h0, 0);
		wr(tcc_pkg::OFF_COUNTER, 32'h0, 0);
		wr(tcc_pkg::OFF_MODE, 32'h80, 0);
		repeat (40) @(posedge aclk);
		rd(tcc_pkg::OFF_COUNTER, 0);
		chk({31'h0, rd_data > 32'h10}, 32'h1, "runs past match");
		endt("counter");
		for (cd = 0; cd < 4; cd++) begin
			wr(tcc_pkg::OFF_OUTPUT_CONTROL_TWO, {24'h0, cd[1:0], 6'h0}, 0);
			wr(tcc_pkg::OFF_MODE, 32'h02, 0);
			cap(4, 1'b1);
			rdc(tcc_pkg::OFF_MODE, cd[0] ? 32'h82 : 32'h02, "trigger rise");
			wr(tcc_pkg::OFF_MODE, 32'h02, 0);
			cap(4, 1'b0);
			rdc(tcc_pkg::OFF_MODE, cd[1] ? 32'h82 : 32'h02, "trigger fall");
		end
		endt("trigger");
		wr(tcc_pkg::OFF_CAPTURE_IO_CD, 32'h88, 0);
		for (i = 0; i < 4; i++) begin
			pol = i[0] ? 3'h6 : 3'h1;
			gv = i[1] ? 16'hffff : 16'h0;
			wr(tcc_pkg::OFF_OUTPUT_CONTROL_TWO, {29'h0, pol}, 0);
			wr(tcc_pkg::OFF_GENERAL_B, {16'h0, gv}, 0);
			wr(tcc_pkg::OFF_GENERAL_C, {16'h0, gv}, 0);
			wr(tcc_pkg::OFF_GENERAL_D, {16'h0, gv}, 0);
			wr(tcc_pkg::OFF_MODE, 32'h81, 0);
			repeat (4) @(posedge aclk);
			@(negedge aclk);
			chk({29'h0, oe_d, oe_c, oe_b}, 32'h7, "outputs driven");
			chk({29'h0, out_d, out_c, out_b}, {29'h0, {3{gv[0]}} ~^ pol}, "level");
		end
		endt("polarity");
		close_out();
	end
endmodule
